// file: src/wsw_pkg.sv
/*
 * Shared constants and types for the watchdog, sleep and wake-up block.
 * Assumes a single 50 MHz system clock; oscillator ticks arrive as
 * one-cycle enables synchronous to that clock.
 */
package wsw_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 14;
    localparam logic [13:0] OFF_STATUS      = 14'h0003;
    localparam logic [13:0] OFF_TIMER_OPT   = 14'h0081;
    localparam logic [13:0] OFF_WDT_CTL     = 14'h0105;
    localparam logic [13:0] OFF_CONFIG      = 14'h2007;

    localparam logic [7:0]  WDT_CTL_RESET   = 8'h08;
    localparam logic [7:0]  TIMER_OPT_RESET = 8'h00;
    localparam logic [7:0]  WDT_CTL_MASK    = 8'h1F;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTL_SOFT_EN_BIT  = 0;
    localparam int CTL_PER_LSB      = 1;
    localparam int CFG_WDT_EN_BIT   = 3;
    localparam int CFG_FOSC_LSB     = 0;
    localparam int OPT_ASSIGN_BIT   = 3;
    localparam int OPT_PS_LSB       = 0;
    localparam int STAT_TO_BIT      = 4;
    localparam int STAT_PD_BIT      = 3;

    // ------------------------------------------------------------------
    // Period select and oscillator modes
    // ------------------------------------------------------------------
    localparam logic [3:0]  PER_MAX_CODE    = 4'hB;
    localparam logic [16:0] PRE_MIN_DIV     = 17'h0_0020;
    localparam logic [2:0]  FOSC_LP         = 3'h0;
    localparam logic [2:0]  FOSC_XT         = 3'h1;
    localparam logic [2:0]  FOSC_HS         = 3'h2;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int LF_OSC_HZ      = 31000;
    localparam int OST_TOSC       = 1024;
    localparam int NUM_WAKE_SRC   = 9;

    typedef enum logic [1:0]
    {
        ST_AWAKE = 2'b00,
        ST_SLEEP = 2'b01,
        ST_OST   = 2'b10
    } wsw_state_e;

    typedef struct packed
    {
        logic [13:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } wsw_bus_s;

endpackage

// file: src/wsw_watchdog_sleep.sv
/*
 * Watchdog timer with 16-bit prescaler and optional postscaler, plus the
 * sleep entry and wake-up sequencer that controls it.
 * Assumes ticks from the low-frequency and system oscillators are one-cycle
 * enables on i_clk, and that the core pulses i_sleep and i_clear_watchdog_instr once per
 * executed instruction.
 */
// Functional notes
// R1 - Watchdog ticks from 31 kHz oscillator; stable flag low
// R2 - Control register resets to 0x08, 16 ms
// R3 - Start-up timer running holds watchdog in reset
// R4 - Prescaler divides 32 up to 65536
// R5 - Configuration enable forces watchdog on
// R6 - Otherwise soft enable bit runs watchdog
// R7 - Period codes double; 1100-1111 reserved
// R8 - Clear on disable, instruction, failure, wake
// R9 - Crystal wake keeps watchdog cleared during start-up
// R10 - Sleep clears watchdog, flags, stops driver, holds pins
// R11 - Watchdog reset never drives master clear low
// R12 - Wake on master clear, watchdog, interrupts
// R13 - Power-down flag set at power-up; time-out cleared
// R14 - Only listed interrupt sources can wake
// R15 - Sleep prefetches next instruction
// R16 - Enable wakes; global enable chooses vector
// R17 - Every wake-up clears the watchdog
// R18 - Pending interrupt makes sleep a no-operation
// R19 - Interrupt during sleep completes then wakes
// R20 - Software clears watchdog, checks power-down flag
// R21 - Crystal interrupt wake waits 1024 oscillator periods
// R22 - Expiry resets when awake, wakes when asleep
`timescale 1ns/1ps

module wsw_watchdog_sleep #(
    parameter logic [7:0] P_CONFIG_RESET = 8'h04,
    parameter int         P_OST_CYCLES   = wsw_pkg::OST_TOSC,
    parameter int         P_NUM_WAKE     = wsw_pkg::NUM_WAKE_SRC
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_b,
    input  wire logic                  i_ce,
    input  wire wsw_pkg::wsw_bus_s     i_bus,
    output logic [7:0]                 o_rdata,
    input  wire logic                  i_lf_tick,
    input  wire logic                  i_osc_tick,
    input  wire logic                  i_clear_watchdog_instr,
    input  wire logic                  i_sleep,
    input  wire logic                  i_osc_fail,
    input  wire logic                  i_master_clear_pin_n,
    input  wire logic                  i_gie,
    input  wire logic [P_NUM_WAKE-1:0] i_wake_irq_en,
    input  wire logic [P_NUM_WAKE-1:0] i_wake_irq_flag,
    output logic                       o_wdt_reset,
    output logic                       o_master_clear_pin_reset,
    output logic                       o_master_clear_pin_oe,
    output logic                       o_wake,
    output logic                       o_vector,
    output logic                       o_prefetch,
    output logic                       o_sleeping,
    output logic                       o_osc_drv_en,
    output logic                       o_io_hold,
    output logic                       o_to_n,
    output logic                       o_pd_n,
    output logic                       o_low_osc_stable_flag
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (P_OST_CYCLES < 1 || P_OST_CYCLES > 1024)
        $error("P_OST_CYCLES must lie in 1..1024");
    if (P_NUM_WAKE < 1)
        $error("P_NUM_WAKE must be at least 1");

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    wsw_pkg::wsw_state_e state_q, state_d;
    logic [7:0]  ctl_q, opt_q, cfg_q;
    logic [15:0] pre_q;
    logic [7:0]  post_q;
    logic [9:0]  ost_q;
    logic        to_n_q, pd_n_q, irq_wake_q;
    logic [7:0]  rdata_q;
    logic        wdt_rst_q, master_clear_pin_rst_q, wake_q, vec_q, pref_q;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire        is_awake   = (state_q == wsw_pkg::ST_AWAKE);
    wire        is_sleep   = (state_q == wsw_pkg::ST_SLEEP);
    wire        is_ost     = (state_q == wsw_pkg::ST_OST);
    wire        irq_pend   = |(i_wake_irq_en & i_wake_irq_flag);
    wire [2:0]  fosc       = cfg_q[wsw_pkg::CFG_FOSC_LSB +: 3];
    wire        crystal    = (fosc == wsw_pkg::FOSC_LP) || (fosc == wsw_pkg::FOSC_XT)
                             || (fosc == wsw_pkg::FOSC_HS);
    wire        wdt_en     = cfg_q[wsw_pkg::CFG_WDT_EN_BIT]
                             | ctl_q[wsw_pkg::CTL_SOFT_EN_BIT];   // see R5 R6
    wire        wdt_run    = wdt_en && !is_ost;                   // see R3
    wire [3:0]  per_code   = ctl_q[wsw_pkg::CTL_PER_LSB +: 4];
    // Reserved period codes behave as the longest ratio rather than wrapping short
    wire [3:0]  per_eff    = (per_code > wsw_pkg::PER_MAX_CODE) ?
                             wsw_pkg::PER_MAX_CODE : per_code;    // see R7
    wire [16:0] pre_limit  = (wsw_pkg::PRE_MIN_DIV << per_eff) - 17'h0_0001; // see R4
    wire        pre_hit    = i_lf_tick && ({1'b0, pre_q} == pre_limit);     // see R1
    wire        post_on    = opt_q[wsw_pkg::OPT_ASSIGN_BIT];
    wire [2:0]  post_sel   = opt_q[wsw_pkg::OPT_PS_LSB +: 3];
    wire [7:0]  post_limit = (8'h01 << post_sel) - 8'h01;
    wire        timeout    = wdt_run && pre_hit && (!post_on || post_q == post_limit);
    wire        sleep_go   = is_awake && i_sleep && !irq_pend;   // see R18
    wire        master_clear_pin_wake  = is_sleep && !i_master_clear_pin_n;
    wire        wake_src   = is_sleep && i_master_clear_pin_n && (timeout || irq_pend); // see R12 R14 R19
    wire        ost_done   = is_ost && i_osc_tick && (ost_q == 10'(P_OST_CYCLES - 1));
    wire        resume     = (wake_src && !crystal) || ost_done;
    wire        wdt_clr    = !wdt_en || i_clear_watchdog_instr || i_osc_fail || sleep_go
                             || wake_src || master_clear_pin_wake || is_ost; // see R8 R10 R17 R9

    // ------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------
    wire        wr_ctl  = i_bus.wr && (i_bus.addr == wsw_pkg::OFF_WDT_CTL);
    wire        wr_opt  = i_bus.wr && (i_bus.addr == wsw_pkg::OFF_TIMER_OPT);
    wire        wr_cfg  = i_bus.wr && (i_bus.addr == wsw_pkg::OFF_CONFIG);
    wire [7:0]  stat_rd = {3'b000, to_n_q, pd_n_q, 3'b000};
    wire [7:0]  rd_mux  = (i_bus.addr == wsw_pkg::OFF_WDT_CTL)   ? ctl_q :
                          (i_bus.addr == wsw_pkg::OFF_TIMER_OPT) ? opt_q :
                          (i_bus.addr == wsw_pkg::OFF_CONFIG)    ? cfg_q :
                          (i_bus.addr == wsw_pkg::OFF_STATUS)    ? stat_rd : 8'h00;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            wsw_pkg::ST_AWAKE:
                if (sleep_go)
                    state_d = wsw_pkg::ST_SLEEP;
            wsw_pkg::ST_SLEEP:
                if (master_clear_pin_wake)
                    state_d = wsw_pkg::ST_AWAKE;
                else if (wake_src)
                    state_d = crystal ? wsw_pkg::ST_OST : wsw_pkg::ST_AWAKE; // see R21
            wsw_pkg::ST_OST:
                if (ost_done)
                    state_d = wsw_pkg::ST_AWAKE;
            default:
                state_d = wsw_pkg::ST_AWAKE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_q    <= wsw_pkg::ST_AWAKE;
            ost_q      <= '0;
            irq_wake_q <= 1'b0;
        end
        else if (i_ce)
        begin
            state_q    <= state_d;
            ost_q      <= (is_ost && i_osc_tick) ? ost_q + 10'h001 : (is_ost ? ost_q : '0);
            if (wake_src)
                irq_wake_q <= !timeout;
        end
    end

    // ------------------------------------------------------------------
    // Prescaler and postscaler
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pre_q  <= '0;
            post_q <= '0;
        end
        else if (i_ce)
        begin
            if (wdt_clr)
            begin
                pre_q  <= '0;
                post_q <= '0;
            end
            else if (wdt_run && i_lf_tick)
            begin
                pre_q <= pre_hit ? '0 : pre_q + 16'h0001;
                if (pre_hit)
                    post_q <= (!post_on || post_q == post_limit) ? '0 : post_q + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status flags, active low
    // ------------------------------------------------------------------
    // The watchdog expiry wins over a clear instruction in the same cycle
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            to_n_q <= 1'b1;
            pd_n_q <= 1'b1;                                       // see R13
        end
        else if (i_ce)
        begin
            if (timeout && !is_ost)
                to_n_q <= 1'b0;                                   // see R13 R22
            else if (sleep_go || i_clear_watchdog_instr)
                to_n_q <= 1'b1;                                   // see R10
            if (sleep_go)
                pd_n_q <= 1'b0;                                   // see R10 R13
            else if (i_clear_watchdog_instr)
                pd_n_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ctl_q   <= wsw_pkg::WDT_CTL_RESET;                    // see R2
            opt_q   <= wsw_pkg::TIMER_OPT_RESET;
            cfg_q   <= P_CONFIG_RESET;
            rdata_q <= 8'h00;
        end
        else if (i_ce)
        begin
            // Unimplemented bits 7:5 never store a one
            if (wr_ctl)
                ctl_q <= i_bus.wdata & wsw_pkg::WDT_CTL_MASK;
            if (wr_opt)
                opt_q <= i_bus.wdata;
            if (wr_cfg)
                cfg_q <= i_bus.wdata;
            rdata_q <= i_bus.rd ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Output events
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wdt_rst_q  <= 1'b0;
            master_clear_pin_rst_q <= 1'b0;
            wake_q     <= 1'b0;
            vec_q      <= 1'b0;
            pref_q     <= 1'b0;
        end
        else if (i_ce)
        begin
            wdt_rst_q  <= is_awake && timeout;                    // see R22
            master_clear_pin_rst_q <= master_clear_pin_wake;                              // see R12
            wake_q     <= resume;                                 // see R12
            vec_q      <= resume && i_gie
                          && (ost_done ? irq_wake_q : !timeout);  // see R16
            pref_q     <= is_awake && i_sleep;                    // see R15
        end
    end

    assign o_rdata               = rdata_q;
    assign o_wdt_reset           = wdt_rst_q;
    assign o_master_clear_pin_reset          = master_clear_pin_rst_q;
    assign o_wake                = wake_q;
    assign o_vector              = vec_q;
    assign o_prefetch            = pref_q;
    assign o_to_n                = to_n_q;
    assign o_pd_n                = pd_n_q;

    // Sleep-only outputs all follow one flop loaded from the next state
    logic sleeping_q;
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            sleeping_q <= 1'b0;
        else if (i_ce)
            sleeping_q <= (state_d == wsw_pkg::ST_SLEEP);         // see R10
    end
    assign o_sleeping   = sleeping_q;
    assign o_io_hold    = sleeping_q;
    assign o_osc_drv_en = !sleeping_q;

    // Constant outputs held in flops so every output leaves a register
    logic zero_q;
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            zero_q <= 1'b0;
        else
            zero_q <= 1'b0;
    end
    assign o_master_clear_pin_oe             = zero_q;                        // see R11
    assign o_low_osc_stable_flag = zero_q;                        // see R1

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    a_stable_flag_low: assert property (!o_low_osc_stable_flag) // see R1
        else $error("oscillator stable flag raised");
    a_master_clear_pin_never_driven: assert property (!o_master_clear_pin_oe) // see R11
        else $error("master clear pin driven");
    a_nop_sleep_keeps: assert property ( // see R18
        i_ce && is_awake && i_sleep && irq_pend |=> is_awake && $stable(o_pd_n))
        else $error("pending interrupt did not make sleep a no-op");
    a_sleep_entry_flags: assert property ( // see R10
        i_ce && sleep_go |=> is_sleep && !o_pd_n && o_to_n && pre_q == 16'h0000)
        else $error("sleep entry did not clear watchdog and flags");
    a_disabled_stays_clear: assert property ( // see R6 R8
        i_ce && !wdt_en |=> pre_q == 16'h0000)
        else $error("disabled watchdog still counting");
    a_config_forces_count: assert property ( // see R5
        i_ce && cfg_q[wsw_pkg::CFG_WDT_EN_BIT] && !is_ost && i_lf_tick && !wdt_clr
        && !pre_hit |=> pre_q == $past(pre_q) + 16'h0001)
        else $error("configuration enable did not run watchdog");
    a_ost_holds_clear: assert property (is_ost |-> pre_q == 16'h0000) // see R3 R9
        else $error("watchdog counting during start-up timer");
    a_awake_expiry_reset: assert property ( // see R22
        i_ce && is_awake && timeout |=> o_wdt_reset && !o_to_n)
        else $error("expiry while awake gave no reset");
    a_irq_wake_fast: assert property ( // see R19 R17
        i_ce && is_sleep && i_master_clear_pin_n && irq_pend && !crystal
        |=> o_wake && is_awake && pre_q == 16'h0000)
        else $error("interrupt did not wake at once");
    a_prefetch_pulse: assert property ( // see R15
        i_ce && is_awake && i_sleep |=> o_prefetch)
        else $error("no prefetch on sleep");
    a_reset_period: assert property ( // see R2
        $rose(i_rst_b) |-> ctl_q == wsw_pkg::WDT_CTL_RESET)
        else $error("control register reset value wrong");
    a_vector_with_wake: assert property (o_vector |-> o_wake) // see R16
        else $error("vector without wake");

    // Wake and reset sequencing
    a_master_clear_pin_wake_reset: assert property ( // see R12 R17
        i_ce && master_clear_pin_wake |=> o_master_clear_pin_reset && is_awake && !o_wake && pre_q == 16'h0000)
        else $error("master clear in sleep did not reset");
    a_crystal_enters_ost: assert property ( // see R21 R9
        i_ce && wake_src && crystal |=> is_ost && !o_wake)
        else $error("crystal wake skipped the start-up wait");
    a_ost_end_wake: assert property ( // see R21
        i_ce && ost_done |=> o_wake && is_awake)
        else $error("start-up wait end gave no wake");
    a_sleep_expiry_wake: assert property ( // see R22 R13
        i_ce && is_sleep && i_master_clear_pin_n && timeout && !crystal
        |=> o_wake && !o_wdt_reset && !o_to_n)
        else $error("expiry in sleep did not wake");
    a_clear_on_events: assert property ( // see R8
        i_ce && (i_clear_watchdog_instr || i_osc_fail) |=> pre_q == 16'h0000)
        else $error("clear or oscillator failure left watchdog running");
    a_vector_needs_gie: assert property ( // see R16
        i_ce && !i_gie |=> !o_vector)
        else $error("vector taken with global enable clear");
    a_awake_no_wake: assert property ( // see R12 R14
        i_ce && is_awake |=> !o_wake)
        else $error("wake pulse while already awake");

    c_wdt_wake: cover property (is_sleep && timeout ##1 is_awake || is_ost);
    c_irq_crystal: cover property (is_sleep && irq_pend && crystal ##[1:1000] o_wake);
    c_awake_reset: cover property (o_wdt_reset);
    c_nop_sleep: cover property (is_awake && i_sleep && irq_pend);
    c_postscale_expiry: cover property (post_on && timeout);

endmodule

// file: tb/wsw_watchdog_sleep_test.sv
/*
 * Self-checking bench for the watchdog, sleep and wake-up block.
 * Assumes the low-frequency tick runs every cycle, so one watchdog tick is one
 * clock, and a shortened start-up count of 4 oscillator ticks.
 */
`timescale 1ns/1ps

module wsw_watchdog_sleep_test;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int OST_N = 4;

    logic              i_clk;
    logic              i_rst_b;
    logic              i_ce;
    wsw_pkg::wsw_bus_s i_bus;
    logic [7:0]        o_rdata;
    logic              i_lf_tick;
    logic              i_osc_tick;
    logic              i_clear_watchdog_instr;
    logic              i_sleep;
    logic              i_osc_fail;
    logic              i_master_clear_pin_n;
    logic              i_gie;
    logic [8:0]        i_wake_irq_en;
    logic [8:0]        i_wake_irq_flag;
    logic              o_wdt_reset;
    logic              o_master_clear_pin_reset;
    logic              o_master_clear_pin_oe;
    logic              o_wake;
    logic              o_vector;
    logic              o_prefetch;
    logic              o_sleeping;
    logic              o_osc_drv_en;
    logic              o_io_hold;
    logic              o_to_n;
    logic              o_pd_n;
    logic              o_low_osc_stable_flag;
    int                fails;
    int                tests_run;
    int                cyc;
    int                n;
    logic [7:0]        v;

    wsw_watchdog_sleep #(.P_OST_CYCLES(OST_N)) uut (
        .i_clk                 (i_clk),
        .i_rst_b               (i_rst_b),
        .i_ce                  (i_ce),
        .i_bus                 (i_bus),
        .o_rdata               (o_rdata),
        .i_lf_tick             (i_lf_tick),
        .i_osc_tick            (i_osc_tick),
        .i_clear_watchdog_instr              (i_clear_watchdog_instr),
        .i_sleep               (i_sleep),
        .i_osc_fail            (i_osc_fail),
        .i_master_clear_pin_n              (i_master_clear_pin_n),
        .i_gie                 (i_gie),
        .i_wake_irq_en         (i_wake_irq_en),
        .i_wake_irq_flag       (i_wake_irq_flag),
        .o_wdt_reset           (o_wdt_reset),
        .o_master_clear_pin_reset          (o_master_clear_pin_reset),
        .o_master_clear_pin_oe             (o_master_clear_pin_oe),
        .o_wake                (o_wake),
        .o_vector              (o_vector),
        .o_prefetch            (o_prefetch),
        .o_sleeping            (o_sleeping),
        .o_osc_drv_en          (o_osc_drv_en),
        .o_io_hold             (o_io_hold),
        .o_to_n                (o_to_n),
        .o_pd_n                (o_pd_n),
        .o_low_osc_stable_flag (o_low_osc_stable_flag)
    );

    always #10 i_clk = ~i_clk;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic stop_test();
        if (fails == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
    endtask

    task automatic rd(input logic [13:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        #1;
        d = o_rdata;
    endtask

    // Pulse one core event for a single cycle: 0 clear, 1 sleep, 2 oscillator fail
    task automatic pulse(input int s);
        @(posedge i_clk);
        i_clear_watchdog_instr   <= (s == 0);
        i_sleep    <= (s == 1);
        i_osc_fail <= (s == 2);
        @(posedge i_clk);
        i_clear_watchdog_instr   <= 1'b0;
        i_sleep    <= 1'b0;
        i_osc_fail <= 1'b0;
        #1;
    endtask

    // Count cycles until any reset or wake pulse shows, bounded by lim
    task automatic wait_out(input int lim, output int k);
        k = 0;
        while (!(o_wake === 1'b1 || o_wdt_reset === 1'b1 || o_master_clear_pin_reset === 1'b1) && k < lim)
        begin
            @(posedge i_clk);
            #1;
            k++;
        end
    endtask

    task automatic irq(input int k, input logic on);
        @(posedge i_clk);
        i_wake_irq_en[k]   <= on;
        i_wake_irq_flag[k] <= on;
    endtask

    task automatic span(input int got, input int exp);
        chk(8'((got >= exp - 2) && (got <= exp + 3)), 8'h01);
    endtask

    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc >= 20000)
        begin
            fails++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial
    begin
        i_clk = 0; i_rst_b = 0; i_ce = 1; i_lf_tick = 1; i_osc_tick = 1;
        i_bus = '{addr: 14'h0000, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        i_clear_watchdog_instr = 0; i_sleep = 0; i_osc_fail = 0; i_master_clear_pin_n = 1; i_gie = 0;
        i_wake_irq_en = '0; i_wake_irq_flag = '0;
        fails = 0; tests_run = 0; cyc = 0;
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1;
        rd(wsw_pkg::OFF_WDT_CTL, v);   chk(v, 8'h08);
        rd(wsw_pkg::OFF_TIMER_OPT, v); chk(v, 8'h00);
        rd(wsw_pkg::OFF_CONFIG, v);    chk(v, 8'h04);
        rd(wsw_pkg::OFF_STATUS, v);    chk(v & 8'h18, 8'h18);
        chk(o_low_osc_stable_flag, 0);
        wr(wsw_pkg::OFF_WDT_CTL, 8'hFF);
        rd(wsw_pkg::OFF_WDT_CTL, v);   chk(v, 8'h1F);
        wr(14'h0050, 8'hA5);
        rd(14'h0050, v);               chk(v, 8'h00);
        // Soft enable off with config enable off: no expiry at all
        wr(wsw_pkg::OFF_WDT_CTL, 8'h00);
        pulse(0); wait_out(200, n);    chk(8'(n == 200), 8'h01);
        // Period codes double the expiry time
        for (int c = 0; c < 4; c++)
        begin
            wr(wsw_pkg::OFF_WDT_CTL, 8'((c << 1) | 1));
            pulse(0); wait_out(1000, n);
            span(n, 32 << c);
            chk(o_wdt_reset, 1);
            chk(o_to_n, 0);
            chk(o_master_clear_pin_oe, 0);
        end
        pulse(0);
        rd(wsw_pkg::OFF_STATUS, v);    chk(v & 8'h10, 8'h10);
        // Oscillator failure restarts the count
        wr(wsw_pkg::OFF_WDT_CTL, 8'h01);
        repeat (20) @(posedge i_clk);
        pulse(2); wait_out(100, n);    span(n, 32);
        // Postscaler assigned at 1:2 doubles the expiry time
        wr(wsw_pkg::OFF_TIMER_OPT, 8'h09);
        pulse(0); wait_out(100, n);    span(n, 64);
        wr(wsw_pkg::OFF_TIMER_OPT, 8'h00);
        // Config enable forces the watchdog on despite soft enable off
        wr(wsw_pkg::OFF_WDT_CTL, 8'h00);
        wr(wsw_pkg::OFF_CONFIG, 8'h0C);
        pulse(0); wait_out(100, n);    span(n, 32);
        // Without oscillator ticks the enabled watchdog stands still
        @(posedge i_clk);
        i_lf_tick <= 1'b0;
        pulse(0); wait_out(100, n);    chk(8'(n == 100), 8'h01);
        @(posedge i_clk);
        i_lf_tick <= 1'b1;
        wr(wsw_pkg::OFF_CONFIG, 8'h04);
        pulse(0);
        // Pending interrupt turns sleep into a no-operation
        irq(0, 1);
        pulse(1);
        chk(o_prefetch, 1);
        chk(o_sleeping, 0);
        chk(o_pd_n, 1);
        irq(0, 0);
        // Every wake-capable interrupt source, both global enable states
        for (int k = 0; k < 9; k++)
        begin
            i_gie <= k[0];
            pulse(1);
            chk(o_prefetch, 1);
            chk({o_sleeping, o_io_hold, o_osc_drv_en}, 8'h06);
            chk({o_pd_n, o_to_n}, 8'h01);
            @(posedge i_clk);
            i_wake_irq_flag[k] <= 1'b1;
            repeat (4) @(posedge i_clk);
            #1;
            chk(o_sleeping, 1);
            irq(k, 1);
            wait_out(10, n);
            chk(o_wake, 1);
            chk(o_vector, 8'(k[0]));
            irq(k, 0);
            #1;
            chk(o_sleeping, 0);
        end
        // Watchdog expiry while asleep wakes instead of resetting
        wr(wsw_pkg::OFF_WDT_CTL, 8'h01);
        pulse(1); wait_out(60, n);
        span(n, 32);
        chk({o_wake, o_wdt_reset}, 8'h02);
        @(posedge i_clk); #1;
        chk(o_to_n, 0);
        wr(wsw_pkg::OFF_WDT_CTL, 8'h00);
        pulse(0);
        // Master clear while asleep resets without a wake pulse
        pulse(1);
        @(posedge i_clk);
        i_master_clear_pin_n <= 1'b0;
        wait_out(10, n);
        chk({o_master_clear_pin_reset, o_wake}, 8'h02);
        @(posedge i_clk);
        i_master_clear_pin_n <= 1'b1;
        // Crystal mode waits for the start-up count before resuming
        wr(wsw_pkg::OFF_CONFIG, 8'h01);
        pulse(1);
        irq(3, 1);
        wait_out(40, n);
        chk(o_wake, 1);
        chk(8'(n), 8'(OST_N + 1));
        irq(3, 0);
        stop_test();
    end

endmodule
